// *** design/smdtx_cfg.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef SMDTX_CFG_SVH
`define SMDTX_CFG_SVH

// Register byte offsets
`define SMDTX_OFF_CTRL      12'h500
`define SMDTX_OFF_XFER_LEN  12'h504
`define SMDTX_OFF_STATUS    12'h508
`define SMDTX_OFF_RX_LIST   12'h540
`define SMDTX_OFF_TX_PTR    12'h544
`define SMDTX_OFF_TX_LIMIT  12'h548
`define SMDTX_OFF_TX_COUNT  12'h54C
`define SMDTX_OFF_TX_LIST   12'h550
`define SMDTX_OFF_CONFIG    12'h554
`define SMDTX_OFF_FILL      12'h5C0

// Field widths and positions
`define SMDTX_LIST_W        2
`define SMDTX_CNT_W         14
`define SMDTX_FILL_W        8
`define SMDTX_CFG_W         3
`define SMDTX_CFG_ORDER     0
`define SMDTX_CFG_CLOCK_PHASE_SEL      1
`define SMDTX_CFG_CLOCK_POLARITY_SEL      2
`define SMDTX_CTRL_START    0
`define SMDTX_STATUS_BUSY   0

// Reset values
`define SMDTX_RST_PTR       32'h0000_0000
`define SMDTX_RST_CNT       14'h0000
`define SMDTX_RST_LIST      2'h0
`define SMDTX_RST_CFG       3'h0
`define SMDTX_RST_FILL      8'h00

// Serial clock half period in core clock cycles
`define SMDTX_DIV_HALF      8'h02

`endif

// *** design/smdtx_pkg.sv ***
// Types shared by the transmit DMA and serial format block
package smdtx_pkg;

  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_LOAD = 2'b01,
    SH_BITS = 2'b10,
    SH_END  = 2'b11
  } smdtx_shift_t;

  typedef logic [7:0] smdtx_byte_t;

  // Mirror a byte so the engine always shifts from bit 7
  function automatic smdtx_byte_t rev8(input smdtx_byte_t b);
    smdtx_byte_t r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7-i];
    end
    return r;
  endfunction

endpackage

// *** design/smdtx_div.sv ***
// Divider producing a one-cycle tick every HALF core clock cycles
`timescale 1ns/1ns
module smdtx_div #(
  parameter int          W    = 8,
  parameter logic [W-1:0] HALF = 8'h02
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // Control
  input  wire logic run,
  output logic      tick
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         tick_r;
  logic         tick_nxt;

  // Count runs only while bits shift so each byte's first edge is a full half
  always_comb begin
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (!run) begin
      cnt_nxt = '0;
    end else if (cnt_r == HALF - W'(1)) begin
      cnt_nxt  = '0;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + W'(1);
    end
  end

  // Registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule

// *** design/smdtx_buf.sv ***
// Small valid/ready buffer between the DMA fetcher and the shift engine
`timescale 1ns/1ns
module smdtx_buf #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset,
  // Filling side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Draining side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] wp_nxt;
  logic [AW-1:0] rp_r;
  logic [AW-1:0] rp_nxt;
  logic [AW:0]   cnt_r;
  logic [AW:0]   cnt_nxt;
  logic          push;
  logic          pop;

  // Honest full and empty from the fill count
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and count update
  always_comb begin
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
    end
    if (pop) begin
      rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - (AW+1)'(1);
    end
  end

  // Registers; storage needs no reset since count guards it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

endmodule

// *** design/smdtx_top.sv ***
// SPI master transmit DMA channel, list selectors and serial format
`timescale 1ns/1ns
`include "smdtx_cfg.svh"
module smdtx_top #(
  parameter int         DIV_W    = 8,
  parameter logic [7:0] DIV_HALF = `SMDTX_DIV_HALF
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // DMA read port
  output logic             dma_req,
  output logic      [31:0] dma_addr,
  input  wire logic        dma_ack,
  input  wire logic [7:0]  dma_rdata,
  // Serial pins
  output logic             spi_sck,
  output logic             spi_mosi,
  input  wire logic        spi_miso,
  output logic             spi_cs_n,
  // Received bytes and state
  output logic      [7:0]  rx_byte,
  output logic             rx_valid,
  output logic             busy
);

  localparam int CW = `SMDTX_CNT_W;

  // Register file state
  logic [31:0]                 tx_ptr_r, tx_ptr_nxt;
  logic [CW-1:0]               tx_limit_r, tx_limit_nxt;
  logic [CW-1:0]               tx_count_r, tx_count_nxt;
  logic [CW-1:0]               xfer_len_r, xfer_len_nxt;
  logic [`SMDTX_LIST_W-1:0]    rx_list_r, rx_list_nxt;
  logic [`SMDTX_LIST_W-1:0]    tx_list_r, tx_list_nxt;
  logic [`SMDTX_CFG_W-1:0]     cfg_r, cfg_nxt;
  logic [`SMDTX_FILL_W-1:0]    fchr_r, fchr_nxt;
  logic [31:0]                 rdata_r, rdata_nxt;
  logic                        start;

  // Fetcher state
  logic [CW-1:0] fetch_idx_r, fetch_idx_nxt;
  logic [CW-1:0] dma_cnt_r, dma_cnt_nxt;
  logic          pend_r, pend_nxt;
  logic          dreq_r, dreq_nxt;
  logic [31:0]   daddr_r, daddr_nxt;
  logic          push_v;
  logic [7:0]    push_d;
  logic          buf_in_ready;
  logic          buf_out_valid;
  logic [7:0]    buf_dout;
  logic          pop;

  // Shifter state
  smdtx_pkg::smdtx_shift_t st_r, st_nxt;
  logic [7:0]    shreg_r, shreg_nxt;
  logic [7:0]    rxsh_r, rxsh_nxt;
  logic [3:0]    half_r, half_nxt;
  logic [CW-1:0] sent_r, sent_nxt;
  logic          sck_r, sck_nxt;
  logic          mosi_r, mosi_nxt;
  logic          csn_r, csn_nxt;
  logic [7:0]    rxb_r, rxb_nxt;
  logic          rxv_r, rxv_nxt;
  logic          tick;
  logic          busy_r;
  logic          lsb_first, clock_phase_sel, clock_polarity_sel;

  assign lsb_first = cfg_r[`SMDTX_CFG_ORDER];
  assign clock_phase_sel      = cfg_r[`SMDTX_CFG_CLOCK_PHASE_SEL];
  assign clock_polarity_sel      = cfg_r[`SMDTX_CFG_CLOCK_POLARITY_SEL];
  assign start     = reg_wr && (reg_addr == `SMDTX_OFF_CTRL) &&
                     reg_wdata[`SMDTX_CTRL_START] && (st_r == smdtx_pkg::SH_IDLE);

  // Register writes and the one-cycle read answer
  always_comb begin
    tx_ptr_nxt   = tx_ptr_r;
    tx_limit_nxt = tx_limit_r;
    tx_count_nxt = tx_count_r;
    xfer_len_nxt = xfer_len_r;
    rx_list_nxt  = rx_list_r;
    tx_list_nxt  = tx_list_r;
    cfg_nxt      = cfg_r;
    fchr_nxt     = fchr_r;
    rdata_nxt    = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        `SMDTX_OFF_TX_PTR:   tx_ptr_nxt   = reg_wdata;
        `SMDTX_OFF_TX_LIMIT: tx_limit_nxt = reg_wdata[CW-1:0];
        `SMDTX_OFF_XFER_LEN: xfer_len_nxt = reg_wdata[CW-1:0];
        `SMDTX_OFF_RX_LIST:  rx_list_nxt  = reg_wdata[`SMDTX_LIST_W-1:0];
        `SMDTX_OFF_TX_LIST:  tx_list_nxt  = reg_wdata[`SMDTX_LIST_W-1:0];
        `SMDTX_OFF_CONFIG:   cfg_nxt      = reg_wdata[`SMDTX_CFG_W-1:0];
        `SMDTX_OFF_FILL:     fchr_nxt     = reg_wdata[`SMDTX_FILL_W-1:0];
        default: ;
      endcase
    end
    if (st_r == smdtx_pkg::SH_END) begin
      tx_count_nxt = dma_cnt_r;
    end
    if (reg_rd) begin
      case (reg_addr)
        `SMDTX_OFF_TX_PTR:   rdata_nxt = tx_ptr_r;
        `SMDTX_OFF_TX_LIMIT: rdata_nxt = {18'h0_0000, tx_limit_r};
        `SMDTX_OFF_TX_COUNT: rdata_nxt = {18'h0_0000, tx_count_r};
        `SMDTX_OFF_XFER_LEN: rdata_nxt = {18'h0_0000, xfer_len_r};
        `SMDTX_OFF_RX_LIST:  rdata_nxt = {30'h0000_0000, rx_list_r};
        `SMDTX_OFF_TX_LIST:  rdata_nxt = {30'h0000_0000, tx_list_r};
        `SMDTX_OFF_CONFIG:   rdata_nxt = {29'h0000_0000, cfg_r};
        `SMDTX_OFF_FILL:     rdata_nxt = {24'h00_0000, fchr_r};
        `SMDTX_OFF_STATUS:   rdata_nxt = {31'h0000_0000, busy};
        default:             rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_ptr_r   <= `SMDTX_RST_PTR;
      tx_limit_r <= `SMDTX_RST_CNT;
      tx_count_r <= `SMDTX_RST_CNT;
      xfer_len_r <= `SMDTX_RST_CNT;
      rx_list_r  <= `SMDTX_RST_LIST;
      tx_list_r  <= `SMDTX_RST_LIST;
      cfg_r      <= `SMDTX_RST_CFG;
      fchr_r     <= `SMDTX_RST_FILL;
      rdata_r    <= 32'h0000_0000;
    end else begin
      tx_ptr_r   <= tx_ptr_nxt;
      tx_limit_r <= tx_limit_nxt;
      tx_count_r <= tx_count_nxt;
      xfer_len_r <= xfer_len_nxt;
      rx_list_r  <= rx_list_nxt;
      tx_list_r  <= tx_list_nxt;
      cfg_r      <= cfg_nxt;
      fchr_r     <= fchr_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  // Fill data: DMA answers when pending, otherwise the fill character
  assign push_v = (pend_r && dma_ack) ||
                  (!pend_r && busy && buf_in_ready &&
                   (fetch_idx_r < xfer_len_r) && (fetch_idx_r >= tx_limit_r));
  assign push_d = pend_r ? dma_rdata : fchr_r;

  // Fetcher keeps one DMA read in flight; buffer space stalls it
  always_comb begin
    fetch_idx_nxt = fetch_idx_r;
    dma_cnt_nxt   = dma_cnt_r;
    pend_nxt      = pend_r;
    dreq_nxt      = 1'b0;
    daddr_nxt     = daddr_r;
    if (start) begin
      fetch_idx_nxt = '0;
      dma_cnt_nxt   = '0;
    end else if (pend_r) begin
      if (dma_ack) begin
        pend_nxt      = 1'b0;
        fetch_idx_nxt = fetch_idx_r + CW'(1);
        dma_cnt_nxt   = dma_cnt_r + CW'(1);
      end
    end else if (busy && buf_in_ready && fetch_idx_r < xfer_len_r) begin
      // buffer read only below the limit
      if (fetch_idx_r < tx_limit_r) begin
        pend_nxt  = 1'b1;
        dreq_nxt  = 1'b1;
        daddr_nxt = tx_ptr_r + {18'h0_0000, fetch_idx_r};
      end else begin
        // past the buffer end use the fill character
        fetch_idx_nxt = fetch_idx_r + CW'(1);
      end
    end
  end

  // Fetcher flops
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fetch_idx_r <= '0;
      dma_cnt_r   <= '0;
      pend_r      <= 1'b0;
      dreq_r      <= 1'b0;
      daddr_r     <= 32'h0000_0000;
    end else begin
      fetch_idx_r <= fetch_idx_nxt;
      dma_cnt_r   <= dma_cnt_nxt;
      pend_r      <= pend_nxt;
      dreq_r      <= dreq_nxt;
      daddr_r     <= daddr_nxt;
    end
  end

  smdtx_buf #(.W(8), .DEPTH(2)) u_buf (
    .core_clk  (core_clk),
    .reset     (reset),
    .in_valid  (push_v),
    .in_data   (push_d),
    .in_ready  (buf_in_ready),
    .out_valid (buf_out_valid),
    .out_data  (buf_dout),
    .out_ready (pop)
  );

  smdtx_div #(.W(DIV_W), .HALF(DIV_HALF)) u_div (
    .core_clk (core_clk),
    .reset    (reset),
    .run      (st_r == smdtx_pkg::SH_BITS),
    .tick     (tick)
  );

  assign pop = (st_r == smdtx_pkg::SH_LOAD) && buf_out_valid &&
               (sent_r != xfer_len_r);

  // Shift engine; each tick is one serial clock half period
  always_comb begin
    logic lead;
    logic smp;
    lead      = 1'b0;
    smp       = 1'b0;
    st_nxt    = st_r;
    shreg_nxt = shreg_r;
    rxsh_nxt  = rxsh_r;
    half_nxt  = half_r;
    sent_nxt  = sent_r;
    sck_nxt   = sck_r;
    mosi_nxt  = mosi_r;
    csn_nxt   = csn_r;
    rxb_nxt   = rxb_r;
    rxv_nxt   = 1'b0;
    case (st_r)
      smdtx_pkg::SH_IDLE: begin
        // clock rests at its idle level
        sck_nxt = clock_polarity_sel;
        csn_nxt = 1'b1;
        if (start) begin
          csn_nxt  = 1'b0;
          sent_nxt = '0;
          st_nxt   = smdtx_pkg::SH_LOAD;
        end
      end
      smdtx_pkg::SH_LOAD: begin
        sck_nxt = clock_polarity_sel;
        if (sent_r == xfer_len_r) begin
          st_nxt = smdtx_pkg::SH_END;
        end else if (buf_out_valid) begin
          // mirror the byte when low bit leads
          shreg_nxt = lsb_first ? smdtx_pkg::rev8(buf_dout) : buf_dout;
          half_nxt  = 4'h0;
          st_nxt    = smdtx_pkg::SH_BITS;
          if (!clock_phase_sel) begin
            mosi_nxt  = shreg_nxt[7];
            shreg_nxt = {shreg_nxt[6:0], 1'b0};
          end
        end
      end
      smdtx_pkg::SH_BITS: begin
        if (tick) begin
          lead     = !half_r[0];
          sck_nxt  = !sck_r;
          half_nxt = half_r + 4'h1;
          // phase picks sampling and shifting edges
          if (lead == !clock_phase_sel) begin
            smp      = 1'b1;
            rxsh_nxt = {rxsh_r[6:0], spi_miso};
          end else begin
            mosi_nxt  = shreg_r[7];
            shreg_nxt = {shreg_r[6:0], 1'b0};
          end
          if (half_r == 4'hF) begin
            rxv_nxt  = 1'b1;
            rxb_nxt  = lsb_first ? smdtx_pkg::rev8(rxsh_nxt) : rxsh_nxt;
            sent_nxt = sent_r + CW'(1);
            st_nxt   = smdtx_pkg::SH_LOAD;
            if (!smp) begin
              mosi_nxt = mosi_r;
            end
          end
        end
      end
      smdtx_pkg::SH_END: begin
        csn_nxt = 1'b1;
        st_nxt  = smdtx_pkg::SH_IDLE;
      end
      default: st_nxt = smdtx_pkg::SH_IDLE;
    endcase
  end

  // Shift engine flops
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_r    <= smdtx_pkg::SH_IDLE;
      shreg_r <= 8'h00;
      rxsh_r  <= 8'h00;
      half_r  <= 4'h0;
      sent_r  <= '0;
      sck_r   <= 1'b0;
      mosi_r  <= 1'b0;
      csn_r   <= 1'b1;
      rxb_r   <= 8'h00;
      rxv_r   <= 1'b0;
      busy_r  <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      shreg_r <= shreg_nxt;
      rxsh_r  <= rxsh_nxt;
      half_r  <= half_nxt;
      sent_r  <= sent_nxt;
      sck_r   <= sck_nxt;
      mosi_r  <= mosi_nxt;
      csn_r   <= csn_nxt;
      rxb_r   <= rxb_nxt;
      rxv_r   <= rxv_nxt;
      busy_r  <= (st_nxt != smdtx_pkg::SH_IDLE);
    end
  end

  // Outputs straight from flops; busy mirrors the state flop exactly
  assign reg_rdata = rdata_r;
  assign dma_req   = dreq_r;
  assign dma_addr  = daddr_r;
  assign spi_sck   = sck_r;
  assign spi_mosi  = mosi_r;
  assign spi_cs_n  = csn_r;
  assign rx_byte   = rxb_r;
  assign rx_valid  = rxv_r;
  assign busy      = busy_r;

  // Checks on the block's outputs and internal state
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_read_idle_zero: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside read answer");
  a_limit_dma_cap: assert property (dma_req |-> $past(fetch_idx_r) < tx_limit_r || $past(reg_wr))
    else $error("DMA read beyond byte limit");
  a_fill_char_used: assert property (push_v && !pend_r |-> push_d == fchr_r && fetch_idx_r >= tx_limit_r)
    else $error("fill byte not the over-read character");
  a_count_at_end: assert property (st_r == smdtx_pkg::SH_END |=> tx_count_r == $past(dma_cnt_r))
    else $error("count not latched at end");
  a_count_held: assert property (st_r != smdtx_pkg::SH_END |=> $stable(tx_count_r))
    else $error("count changed mid transaction");
  a_sck_idle_level: assert property (st_r == smdtx_pkg::SH_LOAD |=> spi_sck == $past(clock_polarity_sel))
    else $error("serial clock not at idle level");
  a_msb_lead_bit: assert property (pop && !clock_phase_sel && !lsb_first |=> spi_mosi == $past(buf_dout[7]))
    else $error("high bit not leading");
  a_lsb_lead_bit: assert property (pop && !clock_phase_sel && lsb_first |=> spi_mosi == $past(buf_dout[0]))
    else $error("low bit not leading");
  a_phase1_shift: assert property (st_r == smdtx_pkg::SH_BITS && tick && !half_r[0] && clock_phase_sel |=> spi_mosi == $past(shreg_r[7]) && spi_sck != $past(spi_sck))
    else $error("phase 1 leading edge did not shift");

endmodule

// *** verif/smdtx_slave_model.sv ***
// Behavioural serial slave that captures every byte seen on the data line
`timescale 1ns/1ns
module smdtx_slave_model (
  // Serial pins
  input  wire logic spi_sck,
  input  wire logic spi_mosi,
  input  wire logic spi_cs_n,
  output logic      spi_miso,
  // Mode as programmed in the master
  input  wire logic clock_polarity_sel,
  input  wire logic clock_phase_sel
);
  localparam logic [7:0] REPLY = 8'h5A;
  logic [7:0] sh;
  int         nbit;
  logic [7:0] got[$];

  initial spi_miso = 1'b0;

  // New frame: drop old capture, present the first reply bit
  always @(negedge spi_cs_n) begin
    got.delete();
    nbit = 0;
    spi_miso = REPLY[7];
  end

  // Released line shows the inverse of its last level, never a stale bit
  always @(posedge spi_cs_n) spi_miso = ~spi_miso;

  // edge selection
  // Leading edge leaves the idle level; phase picks sample or shift
  always @(spi_sck) begin
    if (!spi_cs_n) begin
      if ((spi_sck != clock_polarity_sel) ^ clock_phase_sel) begin
        sh = {sh[6:0], spi_mosi};
        nbit++;
        if (nbit % 8 == 0) got.push_back(sh);
      end else begin
        spi_miso = REPLY[7 - nbit % 8];
      end
    end
  end
endmodule

// *** verif/spi_master_dma_tx_and_format_regs_bench.sv ***
// Self-checking bench for the transmit DMA and serial format block
`timescale 1ns/1ns
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin \
  errors++; $display("wrong value %s expected %h seen %h", what, exp, got); \
  end end
module spi_master_dma_tx_and_format_regs_bench;
  logic        core_clk  = 1'b0;
  logic        reset     = 1'b1;
  logic [11:0] reg_addr  = 12'h000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [31:0] reg_rdata;
  logic        dma_req;
  logic [31:0] dma_addr;
  logic        dma_ack   = 1'b0;
  logic [7:0]  dma_rdata = 8'h00;
  logic        spi_sck;
  logic        spi_mosi;
  logic        spi_miso;
  logic        spi_cs_n;
  logic [7:0]  rx_byte;
  logic        rx_valid;
  logic        busy;
  int          errors    = 0;
  int          checks    = 0;
  int          nreq      = 0;
  int          ack_wait  = 1;
  int          wcnt      = 0;
  int          nrx       = 0;
  logic        pend      = 1'b0;
  logic [2:0]  cfg       = 3'h0;
  logic [31:0] ptr       = 32'h2000_0010;
  logic [31:0] next_a    = 32'h0000_0000;
  logic [31:0] d;
  logic [7:0]  mem[16];
  logic [11:0] offs[8]   = '{12'h540, 12'h544, 12'h548, 12'h54C,
                             12'h550, 12'h554, 12'h5C0, 12'h5FC};
  logic [31:0] masks[8]  = '{32'h0000_0003, 32'hFFFF_FFFF, 32'h0000_3FFF,
                             32'h0000_0000, 32'h0000_0003, 32'h0000_0007,
                             32'h0000_00FF, 32'h0000_0000};

  always #20 core_clk = ~core_clk;

  smdtx_top u_dut (
    .core_clk (core_clk),  .reset    (reset),
    .reg_addr (reg_addr),  .reg_wdata(reg_wdata),
    .reg_wr   (reg_wr),    .reg_rd   (reg_rd),
    .reg_rdata(reg_rdata), .dma_req  (dma_req),
    .dma_addr (dma_addr),  .dma_ack  (dma_ack),
    .dma_rdata(dma_rdata), .spi_sck  (spi_sck),
    .spi_mosi (spi_mosi),  .spi_miso (spi_miso),
    .spi_cs_n (spi_cs_n),  .rx_byte  (rx_byte),
    .rx_valid (rx_valid),  .busy     (busy)
  );

  smdtx_slave_model u_slave (
    .spi_sck (spi_sck),  .spi_mosi(spi_mosi), .spi_cs_n(spi_cs_n),
    .spi_miso(spi_miso), .clock_polarity_sel    (cfg[2]),   .clock_phase_sel    (cfg[1])
  );

  // Memory with a programmable answer delay; data line scrambles when idle
  always @(posedge core_clk) begin
    dma_ack <= 1'b0;
    if (dma_req) begin
      // ascending reads from the programmed buffer start
      `CHK("dma address", next_a, dma_addr)
      next_a = next_a + 32'h0000_0001;
      nreq++;
      pend <= 1'b1;
      wcnt <= ack_wait;
    end else if (pend) begin
      if (wcnt <= 1) begin
        dma_ack   <= 1'b1;
        dma_rdata <= mem[dma_addr[3:0]];
        pend      <= 1'b0;
      end else begin
        wcnt <= wcnt - 1;
      end
    end else begin
      dma_rdata <= ~dma_rdata;
    end
  end

  // Every received byte is the slave's fixed reply, a bit palindrome
  always @(posedge core_clk) begin
    if (rx_valid === 1'b1) begin
      nrx++;
      `CHK("received byte", 8'h5A, rx_byte)
    end
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data is only valid in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic chk_rd(input string what, input logic [11:0] a,
                        input logic [31:0] exp);
    rd(a, d);
    `CHK(what, exp, d)
  endtask

  function automatic logic [7:0] mirror(input logic [7:0] b);
    for (int i = 0; i < 8; i++) mirror[i] = b[7-i];
  endfunction

  task automatic end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One transfer: program, start, wait bounded, compare wire and count
  task automatic run(input logic [2:0] c, input int len, input int lim,
                     input logic [7:0] fill, input int w);
    logic [31:0] prev;
    logic [7:0]  e;
    int          n;
    rd(12'h54C, prev);
    cfg      = c;
    ack_wait = w;
    nreq     = 0;
    nrx      = 0;
    next_a   = ptr;
    wr(12'h544, ptr);
    wr(12'h548, 32'(lim));
    wr(12'h504, 32'(len));
    wr(12'h554, {29'h0, c});
    wr(12'h5C0, {24'h0, fill});
    `CHK("idle clock level", c[2], spi_sck)
    wr(12'h500, 32'h0000_0001);
    chk_rd("count during run", 12'h54C, prev);
    n = 0;
    while (busy !== 1'b0 && n < 4000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 4000) begin
      errors++;
      end_sim();
    end
    `CHK("buffer reads", lim, nreq)
    `CHK("bytes received", len, nrx)
    `CHK("select released", 1'b1, spi_cs_n)
    `CHK("bytes on wire", len, u_slave.got.size())
    for (int i = 0; i < len && i < u_slave.got.size(); i++) begin
      e = (i < lim) ? mem[i] : fill;
      if (c[0]) e = mirror(e);
      `CHK("wire byte", e, u_slave.got[i])
    end
    chk_rd("byte count", 12'h54C, 32'(lim));
    $display("test mode %0d len %0d limit %0d done", c, len, lim);
  endtask

  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 8'(i * 37 + 5);
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    // Reset values, then all-ones write to see field widths and read-only
    for (int i = 0; i < 8; i++) begin
      chk_rd("reset value", offs[i], 32'h0000_0000);
    end
    for (int i = 0; i < 8; i++) begin
      wr(offs[i], 32'hFFFF_FFFF);
      chk_rd("readback", offs[i], masks[i]);
    end
    $display("test register map done");
    // Every order, phase and polarity with one over-read byte
    for (int c = 0; c < 8; c++) begin
      run(3'(c), 3, 2, 8'hC3 ^ 8'(c), (c % 2) ? 1 : 3);
    end
    run(3'h1, 2, 0, 8'h7E, 1);
    run(3'h6, 4, 4, 8'h00, 2);
    end_sim();
  end
endmodule
